// [cstc_afe_model.sv]
// front end model: measures phase lengths and comparisons of each sensing
`timescale 1ns/10ps
module cstc_afe_model (
  input  wire logic        clock,
  input  wire logic        initial_apply,
  input  wire logic        apply,
  input  wire logic        comparator_wait,
  input  wire logic        compare_strobe,
  output logic      [15:0] n_init,
  output logic      [15:0] n_wait,
  output logic      [15:0] n_apply,
  output logic      [7:0]  n_strobe
);
  logic prev_init = 1'b0;

  // tallies restart when an initial apply begins, so one sensing is seen at a time
  always_ff @(posedge clock) begin
    prev_init <= initial_apply;
    if (initial_apply && !prev_init) begin
      n_init   <= 16'h0001;
      n_wait   <= 16'h0000;
      n_apply  <= 16'h0000;
      n_strobe <= 8'h00;
    end else begin
      n_init   <= n_init + {15'h0000, initial_apply};
      n_wait   <= n_wait + {15'h0000, comparator_wait};
      n_apply  <= n_apply + {15'h0000, apply};
      n_strobe <= n_strobe + {7'h00, compare_strobe};
    end
  end
endmodule

// [cstc_cfg.svh]
// register offsets, reset values and timing counts of the sensing timing bank
`ifndef CSTC_CFG_SVH
`define CSTC_CFG_SVH

// register offsets of the serial bus
`define CSTC_ADDR_MODE              8'hE0
`define CSTC_ADDR_NORMAL_COUNT      8'hE3
`define CSTC_ADDR_NORMAL_WAIT       8'hE4
`define CSTC_ADDR_NORMAL_APPLY      8'hE5
`define CSTC_ADDR_NORMAL_INIT_APPLY 8'hE6
`define CSTC_ADDR_CHECK_COUNT       8'hE7
`define CSTC_ADDR_CHECK_WAIT        8'hE8
`define CSTC_ADDR_CHECK_APPLY       8'hE9
`define CSTC_ADDR_CHECK_INIT_APPLY  8'hEA
`define CSTC_ADDR_STATUS            8'hF8

// index of each timing register inside the storage array
`define CSTC_IDX_NORMAL_COUNT       3'h0
`define CSTC_IDX_NORMAL_WAIT        3'h1
`define CSTC_IDX_NORMAL_APPLY       3'h2
`define CSTC_IDX_NORMAL_INIT_APPLY  3'h3
`define CSTC_IDX_CHECK_COUNT        3'h4
`define CSTC_IDX_CHECK_WAIT         3'h5
`define CSTC_IDX_CHECK_APPLY        3'h6
`define CSTC_IDX_CHECK_INIT_APPLY   3'h7
`define CSTC_TIMING_REGS            8

// field positions
`define CSTC_MODE_INTERMITTENT_BIT  0
`define CSTC_STATUS_BUSY_BIT        0
`define CSTC_STATUS_KIND_LSB        1
`define CSTC_STATUS_CAL_PEND_BIT    3

// reset values
`define CSTC_RST_TIMING             8'h00
`define CSTC_RST_MODE               8'h00

// 7-bit serial bus address, arbitrary value
`define CSTC_BUS_ADDR               7'h2A

// one phase step of a timing field, in ns, and its length in clock cycles
`define CSTC_CLK_PERIOD_NS          10
`define CSTC_PHASE_UNIT_NS          1000
`define CSTC_PHASE_UNIT_CYCLES      ((`CSTC_PHASE_UNIT_NS + `CSTC_CLK_PERIOD_NS - 1) / `CSTC_CLK_PERIOD_NS)

`endif

// [cstc_i2c_slave.sv]
// 2-wire serial slave with an auto-incrementing register pointer
`timescale 1ns/10ps
`include "cstc_cfg.svh"

module cstc_i2c_slave (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);

  cstc_pkg::cstc_i2c_state_t state;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_f;
  logic       sda_f;
  logic       scl_prev;
  logic       sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       read_mode;
  logic       ptr_phase;
  logic       master_ack;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // pin synchronisers; a level counts once the last two stages agree
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[2];
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  assign scl_rise   = scl_f & ~scl_prev;
  assign scl_fall   = ~scl_f & scl_prev;
  assign start_cond = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_cond  = scl_f & scl_prev & ~sda_prev & sda_f;
  assign sda_out    = 1'b0;                     // open drain: only ever pulls low

  // byte engine; start and stop override any phase
  always_ff @(posedge clock) begin
    if (srst) begin
      state      <= cstc_pkg::I2C_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      read_mode  <= 1'b0;
      ptr_phase  <= 1'b0;
      master_ack <= 1'b0;
      sda_oe_n   <= 1'b1;
      reg_addr   <= 8'h00;
      reg_wr     <= 1'b0;
      reg_wdata  <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      if (start_cond) begin
        state    <= cstc_pkg::I2C_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state    <= cstc_pkg::I2C_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        unique case (state)
          cstc_pkg::I2C_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          cstc_pkg::I2C_ADDR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (shreg[7:1] == `CSTC_BUS_ADDR) begin
                sda_oe_n  <= 1'b0;               // acknowledge own address
                read_mode <= shreg[0];
                state     <= cstc_pkg::I2C_ADDR_ACK;
              end else begin
                state <= cstc_pkg::I2C_IDLE;
              end
            end
          end
          cstc_pkg::I2C_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (read_mode) begin
                shreg    <= reg_rdata;
                sda_oe_n <= reg_rdata[7];
                state    <= cstc_pkg::I2C_RD;
              end else begin
                sda_oe_n  <= 1'b1;
                ptr_phase <= 1'b1;               // first written byte is the pointer
                state     <= cstc_pkg::I2C_WR;
              end
            end
          end
          cstc_pkg::I2C_WR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              sda_oe_n <= 1'b0;
              state    <= cstc_pkg::I2C_WR_ACK;
              if (ptr_phase) begin
                reg_addr <= shreg;
              end else begin
                reg_wr    <= 1'b1;
                reg_wdata <= shreg;
              end
            end
          end
          cstc_pkg::I2C_WR_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              bit_cnt  <= 4'h0;
              state    <= cstc_pkg::I2C_WR;
              if (!ptr_phase) reg_addr <= reg_addr + 8'h01;
              ptr_phase <= 1'b0;
            end
          end
          cstc_pkg::I2C_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_n <= 1'b1;
                reg_addr <= reg_addr + 8'h01;   // early, so next data settles
                state    <= cstc_pkg::I2C_RD_ACK;
              end else begin
                shreg    <= {shreg[6:0], 1'b0};
                sda_oe_n <= shreg[6];
              end
            end
          end
          cstc_pkg::I2C_RD_ACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_f;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (master_ack) begin
                shreg    <= reg_rdata;
                sda_oe_n <= reg_rdata[7];
                state    <= cstc_pkg::I2C_RD;
              end else begin
                state <= cstc_pkg::I2C_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// [cstc_phase_timer.sv]
// phase timer: counts a timing field in whole phase units
`timescale 1ns/10ps
`include "cstc_cfg.svh"

module cstc_phase_timer (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic [7:0] length,
  output logic            expired
);

  localparam logic [6:0] UNIT_LAST = 7'(`CSTC_PHASE_UNIT_CYCLES - 1);

  logic [6:0] prescale;
  logic [7:0] remaining;
  logic       unit_tick;

  // prescaler restarts at load so a phase lasts length units and one cycle
  always_ff @(posedge clock) begin
    if (srst || load) begin
      prescale <= 7'h00;
    end else if (remaining != 8'h00) begin
      prescale <= unit_tick ? 7'h00 : prescale + 7'h01;
    end
  end

  assign unit_tick = (prescale == UNIT_LAST);

  // remaining units of the running phase
  always_ff @(posedge clock) begin
    if (srst) begin
      remaining <= 8'h00;
    end else if (load) begin
      remaining <= length;
    end else if (remaining != 8'h00 && unit_tick) begin
      remaining <= remaining - 8'h01;
    end
  end

  assign expired = (remaining == 8'h00);

endmodule

// [cstc_pkg.sv]
// types shared by the sensing timing bank
package cstc_pkg;

  // sequencer phases
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_INIT_APPLY,
    SEQ_CMP_WAIT,
    SEQ_APPLY,
    SEQ_COMPARE,
    SEQ_DONE
  } cstc_seq_state_t;

  // serial slave phases
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_WR,
    I2C_WR_ACK,
    I2C_RD,
    I2C_RD_ACK
  } cstc_i2c_state_t;

  // kind of sensing, as shown by sense_kind and in status
  typedef enum logic [1:0] {
    KIND_NORMAL = 2'h0,
    KIND_CHECK  = 2'h1,
    KIND_CAL    = 2'h2
  } cstc_kind_t;

endpackage

// [cstc_timing_monitor.sv]
// checker of sensing phase order at the top ports
`timescale 1ns/10ps
module cstc_timing_monitor (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       afe_initial_apply,
  input  wire logic       afe_apply,
  input  wire logic       afe_comparator_wait,
  input  wire logic       afe_compare_strobe,
  input  wire logic       sense_busy,
  input  wire logic [1:0] sense_kind,
  input  wire logic       sense_done,
  input  wire logic       intermittent_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // phase order, idle quiet and kind rules of each sensing
  strobe_after_apply_a: assert property (afe_compare_strobe |-> $fell(afe_apply))
    else $error("strobe not after apply");
  start_initial_a: assert property ($rose(sense_busy) |-> afe_initial_apply)
    else $error("sensing not opened by initial apply");
  initial_to_wait_a: assert property ($fell(afe_initial_apply) |-> afe_comparator_wait)
    else $error("initial apply not followed by wait");
  wait_exit_a: assert property ($fell(afe_comparator_wait) |-> ##[0:1] (afe_apply || sense_done))
    else $error("wait left to wrong phase");
  done_close_a: assert property (sense_done |-> sense_busy ##1 (!sense_done && !sense_busy))
    else $error("done not a closing strobe");
  phase_onehot_a: assert property ($onehot0({afe_initial_apply, afe_apply, afe_comparator_wait,
                                             afe_compare_strobe}))
    else $error("phases overlap");
  idle_quiet_a: assert property (!sense_busy |-> !(afe_apply || afe_initial_apply || afe_compare_strobe))
    else $error("front end driven while idle");
  kind_hold_a: assert property (sense_busy && $past(sense_busy) |-> $stable(sense_kind))
    else $error("kind changed in a sensing");
  check_mode_a: assert property ($rose(sense_busy) && sense_kind == cstc_pkg::KIND_CHECK
                                 |-> $past(intermittent_active))
    else $error("check sensing without intermittent mode");
  normal_mode_a: assert property ($rose(sense_busy) && sense_kind == cstc_pkg::KIND_NORMAL
                                  |-> !$past(intermittent_active))
    else $error("normal sensing in intermittent mode");

  // main scenarios reached
  cover property ($rose(sense_busy) && sense_kind == cstc_pkg::KIND_NORMAL);
  cover property ($rose(sense_busy) && sense_kind == cstc_pkg::KIND_CHECK);
  cover property ($rose(sense_busy) && sense_kind == cstc_pkg::KIND_CAL);
endmodule

bind cstc_top cstc_timing_monitor mon (.clock(clock), .srst(srst), .afe_initial_apply(afe_initial_apply),
  .afe_apply(afe_apply), .afe_comparator_wait(afe_comparator_wait), .afe_compare_strobe(afe_compare_strobe),
  .sense_busy(sense_busy), .sense_kind(sense_kind), .sense_done(sense_done),
  .intermittent_active(intermittent_active));

// [cstc_top.sv]
// sensing timing bank: serial register file and sensing phase sequencer
`timescale 1ns/10ps
`include "cstc_cfg.svh"

// Behaviour
// - normal sensing performs as many comparisons as normal_compare_count gives.
// - normal sensing holds the comparator wait for normal_comparator_wait units.
// - each normal apply phase lasts normal_apply_time units.
// - the normal initial apply phase lasts normal_initial_apply_time units.
// - check and calibration sensing perform check_compare_count comparisons.
// - check and calibration comparator wait lasts check_comparator_wait units.
// - check and calibration apply phases last check_apply_time units.
// - check and calibration initial apply lasts check_initial_apply_time units.
// - check sensing replaces normal sensing only while intermittent_enable is set.
module cstc_top (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic sense_start,
  input  wire logic cal_request,
  output logic      afe_initial_apply,
  output logic      afe_apply,
  output logic      afe_comparator_wait,
  output logic      afe_compare_strobe,
  output logic      sense_busy,
  output logic [1:0] sense_kind,
  output logic      sense_done,
  output logic      intermittent_active
);

  // register storage and bus side
  logic [7:0] timing_reg [0:`CSTC_TIMING_REGS-1];
  logic [7:0] mode_reg;
  logic [7:0] bus_addr;
  logic       bus_wr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic [7:0] status_reg;
  logic [3:0] addr_hit;

  // sequencer
  cstc_pkg::cstc_seq_state_t state;
  cstc_pkg::cstc_seq_state_t next_state;
  cstc_pkg::cstc_kind_t      kind;
  cstc_pkg::cstc_kind_t      next_kind;
  logic       cal_pending;
  logic       start_now;
  logic [7:0] sh_count;
  logic [7:0] sh_wait;
  logic [7:0] sh_apply;
  logic [7:0] compares_left;
  logic       timer_load;
  logic [7:0] timer_length;
  logic       timer_expired;
  logic [2:0] set_base;

  // maps a bus address onto the timing array; bit 3 flags a hit
  function automatic logic [3:0] cstc_decode(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - `CSTC_ADDR_NORMAL_COUNT;
    if (addr >= `CSTC_ADDR_NORMAL_COUNT && addr <= `CSTC_ADDR_CHECK_INIT_APPLY) begin
      cstc_decode = {1'b1, rel[2:0]};
    end else begin
      cstc_decode = 4'h0;
    end
  endfunction

  // first index of the parameter set for a sensing kind
  function automatic logic [2:0] cstc_set_base(input cstc_pkg::cstc_kind_t k);
    cstc_set_base = (k == cstc_pkg::KIND_NORMAL) ? `CSTC_IDX_NORMAL_COUNT : `CSTC_IDX_CHECK_COUNT;
  endfunction

  cstc_i2c_slave u_bus (
    .clock     (clock),
    .srst      (srst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe_n  (sda_oe_n),
    .reg_addr  (bus_addr),
    .reg_wr    (bus_wr),
    .reg_wdata (bus_wdata),
    .reg_rdata (bus_rdata)
  );

  // decoded once, shared by the write port and the read mux
  assign addr_hit = cstc_decode(bus_addr);

  // timing registers; writes to unmapped offsets are dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < `CSTC_TIMING_REGS; i++) begin
        timing_reg[i] <= `CSTC_RST_TIMING;
      end
    end else if (bus_wr && addr_hit[3]) begin
      timing_reg[addr_hit[2:0]] <= bus_wdata;
    end
  end

  // mode register; only the intermittent enable is used here, the rest is storage
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= `CSTC_RST_MODE;
    end else if (bus_wr && bus_addr == `CSTC_ADDR_MODE) begin
      mode_reg <= bus_wdata;
    end
  end

  assign intermittent_active = mode_reg[`CSTC_MODE_INTERMITTENT_BIT];

  // read-only status of the sequencer
  always_comb begin
    status_reg = 8'h00;
    status_reg[`CSTC_STATUS_BUSY_BIT] = sense_busy;
    status_reg[`CSTC_STATUS_KIND_LSB +: 2] = kind;
    status_reg[`CSTC_STATUS_CAL_PEND_BIT] = cal_pending;
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    if (addr_hit[3]) begin
      bus_rdata = timing_reg[addr_hit[2:0]];
    end else if (bus_addr == `CSTC_ADDR_MODE) begin
      bus_rdata = mode_reg;
    end else if (bus_addr == `CSTC_ADDR_STATUS) begin
      bus_rdata = status_reg;
    end else begin
      bus_rdata = 8'h00;
    end
  end

  // calibration request waits for the sequencer; a new request beats the clear
  always_ff @(posedge clock) begin
    if (srst) begin
      cal_pending <= 1'b0;
    end else if (cal_request) begin
      cal_pending <= 1'b1;
    end else if (state == cstc_pkg::SEQ_IDLE && next_state == cstc_pkg::SEQ_INIT_APPLY
                 && next_kind == cstc_pkg::KIND_CAL) begin
      cal_pending <= 1'b0;
    end
  end

  // calibration first, then check sensing when intermittent, else normal
  always_comb begin
    if (cal_pending) begin
      next_kind = cstc_pkg::KIND_CAL;
    end else if (intermittent_active) begin
      next_kind = cstc_pkg::KIND_CHECK;
    end else begin
      next_kind = cstc_pkg::KIND_NORMAL;
    end
  end

  assign start_now = sense_start | cal_pending;
  assign set_base  = cstc_set_base(next_kind);

  // phase sequence: initial apply, comparator wait, then apply and compare per count
  always_comb begin
    next_state   = state;
    timer_load   = 1'b0;
    timer_length = 8'h00;
    unique case (state)
      cstc_pkg::SEQ_IDLE: begin
        if (start_now) begin
          next_state   = cstc_pkg::SEQ_INIT_APPLY;
          timer_load   = 1'b1;
          timer_length = timing_reg[set_base + 3'h3];
        end
      end
      cstc_pkg::SEQ_INIT_APPLY: begin
        if (timer_expired) begin
          next_state   = cstc_pkg::SEQ_CMP_WAIT;
          timer_load   = 1'b1;
          timer_length = sh_wait;
        end
      end
      cstc_pkg::SEQ_CMP_WAIT: begin
        if (timer_expired) begin
          if (sh_count == 8'h00) begin
            next_state = cstc_pkg::SEQ_DONE;
          end else begin
            next_state   = cstc_pkg::SEQ_APPLY;
            timer_load   = 1'b1;
            timer_length = sh_apply;
          end
        end
      end
      cstc_pkg::SEQ_APPLY: begin
        if (timer_expired) next_state = cstc_pkg::SEQ_COMPARE;
      end
      cstc_pkg::SEQ_COMPARE: begin
        if (compares_left == 8'h01) begin
          next_state = cstc_pkg::SEQ_DONE;
        end else begin
          next_state   = cstc_pkg::SEQ_APPLY;
          timer_load   = 1'b1;
          timer_length = sh_apply;
        end
      end
      cstc_pkg::SEQ_DONE: begin
        next_state = cstc_pkg::SEQ_IDLE;
      end
      default: begin
        next_state = cstc_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= cstc_pkg::SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // parameter set is frozen at start, so bus writes never tear a running sensing
  always_ff @(posedge clock) begin
    if (srst) begin
      kind     <= cstc_pkg::KIND_NORMAL;
      sh_count <= 8'h00;
      sh_wait  <= 8'h00;
      sh_apply <= 8'h00;
    end else if (state == cstc_pkg::SEQ_IDLE && start_now) begin
      kind     <= next_kind;
      sh_count <= timing_reg[set_base];
      sh_wait  <= timing_reg[set_base + 3'h1];
      sh_apply <= timing_reg[set_base + 3'h2];
    end
  end

  // comparisons still to do in this sensing
  always_ff @(posedge clock) begin
    if (srst) begin
      compares_left <= 8'h00;
    end else if (state == cstc_pkg::SEQ_CMP_WAIT && next_state == cstc_pkg::SEQ_APPLY) begin
      compares_left <= sh_count;
    end else if (state == cstc_pkg::SEQ_COMPARE) begin
      compares_left <= compares_left - 8'h01;
    end
  end

  cstc_phase_timer u_timer (
    .clock   (clock),
    .srst    (srst),
    .load    (timer_load),
    .length  (timer_length),
    .expired (timer_expired)
  );

  // front-end controls registered from the next phase, so they line up with it
  always_ff @(posedge clock) begin
    if (srst) begin
      afe_initial_apply   <= 1'b0;
      afe_apply           <= 1'b0;
      afe_comparator_wait <= 1'b0;
      afe_compare_strobe  <= 1'b0;
      sense_done          <= 1'b0;
      sense_busy          <= 1'b0;
      sense_kind          <= 2'h0;
    end else begin
      afe_initial_apply   <= (next_state == cstc_pkg::SEQ_INIT_APPLY);
      afe_apply           <= (next_state == cstc_pkg::SEQ_APPLY);
      afe_comparator_wait <= (next_state == cstc_pkg::SEQ_CMP_WAIT);
      afe_compare_strobe  <= (next_state == cstc_pkg::SEQ_COMPARE);
      sense_done          <= (next_state == cstc_pkg::SEQ_DONE);
      sense_busy          <= (next_state != cstc_pkg::SEQ_IDLE);
      if (state == cstc_pkg::SEQ_IDLE && start_now) sense_kind <= next_kind;
    end
  end

endmodule

// [tb_cap_sense_timing_config.sv]
// self-checking bench of the sensing timing bank
`timescale 1ns/10ps
`include "cstc_cfg.svh"
module tb_cap_sense_timing_config;
  logic        clock;
  logic        srst;
  logic        scl;
  logic        sda_m;
  logic        sense_start;
  logic        cal_request;
  logic        sda_oe_n;
  logic        afe_initial_apply;
  logic        afe_apply;
  logic        afe_comparator_wait;
  logic        afe_compare_strobe;
  logic        sense_busy;
  logic [1:0]  sense_kind;
  logic        sense_done;
  logic        intermittent_active;
  logic [15:0] n_init;
  logic [15:0] n_wait;
  logic [15:0] n_apply;
  logic [7:0]  n_strobe;
  logic [7:0]  rb [8];
  int          errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  wire         sda = sda_oe_n ? sda_m : 1'b0;
  localparam logic [7:0] TV [8] = '{8'h03, 8'h01, 8'h02, 8'h04, 8'h02, 8'h00, 8'h01, 8'h03};
  localparam logic [7:0] AW = {`CSTC_BUS_ADDR, 1'b0};

  cstc_top uut (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
    .sense_start(sense_start), .cal_request(cal_request), .afe_initial_apply(afe_initial_apply),
    .afe_apply(afe_apply), .afe_comparator_wait(afe_comparator_wait), .afe_compare_strobe(afe_compare_strobe),
    .sense_busy(sense_busy), .sense_kind(sense_kind), .sense_done(sense_done),
    .intermittent_active(intermittent_active));
  cstc_afe_model afe (.clock(clock), .initial_apply(afe_initial_apply), .apply(afe_apply),
    .comparator_wait(afe_comparator_wait), .compare_strobe(afe_compare_strobe),
    .n_init(n_init), .n_wait(n_wait), .n_apply(n_apply), .n_strobe(n_strobe));

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic results;
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a phase may carry one transition cycle beyond its units
  function automatic logic [15:0] span(input logic [15:0] seen, input int unsigned n, input int unsigned reps);
    int unsigned lo;
    lo = reps * ((n == 0) ? 1 : n * 100);
    return (seen >= lo && seen <= lo + reps) ? seen : lo[15:0];
  endfunction

  // a third of a bit time keeps both line levels well above the pin filter
  task automatic hp;
    repeat (10) @(posedge clock);
  endtask

  task automatic clk_bit(input logic b, output logic r);
    sda_m <= b;
    hp;
    scl <= 1'b1;
    hp;
    r = sda;
    scl <= 1'b0;
    hp;
  endtask

  task automatic start;
    sda_m <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_m <= 1'b0;
    hp;
    scl <= 1'b0;
    hp;
  endtask

  task automatic stop;
    sda_m <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_m <= 1'b1;
    hp;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic k);
    for (int j = 7; j >= 0; j--) clk_bit(tx[j], rx[j]);
    clk_bit(last, k);
  endtask

  task automatic wb(input logic [7:0] b);
    logic [7:0] d;
    logic       k;
    xfer(b, 1'b1, d, k);
    check("ack", {15'h0000, k}, 16'h0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    start;
    wb(AW);
    wb(a);
    wb(v);
    stop;
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    logic k;
    start;
    wb(AW);
    wb(a);
    start;
    wb(AW | 8'h01);
    for (int j = 0; j < n; j++) xfer(8'hFF, j == n - 1, rb[j], k);
    stop;
  endtask

  // one sensing; poke asks again mid-run, which must be dropped
  task automatic sense(input logic cal, input logic poke, input cstc_pkg::cstc_kind_t kind,
                       input int unsigned c, input int unsigned w, input int unsigned a, input int unsigned i);
    int k;
    k = 0;
    sense_start <= ~cal;
    cal_request <= cal;
    @(posedge clock);
    sense_start <= 1'b0;
    cal_request <= 1'b0;
    repeat (3) @(posedge clock);
    sense_start <= poke;
    @(posedge clock);
    sense_start <= 1'b0;
    do begin
      @(negedge clock);
      k++;
    end while (sense_done !== 1'b1 && k < 40000);
    check("kind", {14'h0000, sense_kind}, {14'h0000, kind});
    check("compares", {8'h00, n_strobe}, c[15:0]);
    check("initial apply", n_init, span(n_init, i, 1));
    check("comparator wait", n_wait, span(n_wait, w, 1));
    check("apply", n_apply, span(n_apply, a, c));
    @(posedge clock);
    repeat (3) @(negedge clock);
    check("busy after sensing", {15'h0000, sense_busy}, 16'h0000);
    @(posedge clock);
  endtask

  task automatic t_reset;
    @(negedge clock);
    check("idle outputs", {9'h000, afe_initial_apply, afe_apply, afe_comparator_wait, afe_compare_strobe,
      sense_busy, sense_done, intermittent_active}, 16'h0000);
    hp;
    rd(8'hE3, 8);
    for (int j = 0; j < 8; j++) check("reset value", {8'h00, rb[j]}, 16'h0000);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    logic       k;
    for (int j = 0; j < 8; j++) wr(8'hE3 + 8'(j), TV[j]);
    rd(8'hE3, 8);
    for (int j = 0; j < 8; j++) check("readback", {8'h00, rb[j]}, {8'h00, TV[j]});
    wr(8'hD0, 8'hA5);
    rd(8'hD0, 1);
    check("unmapped", {8'h00, rb[0]}, 16'h0000);
    start;
    xfer(AW ^ 8'h02, 1'b1, d, k);
    stop;
    check("foreign address", {15'h0000, k}, 16'h0001);
  endtask

  task automatic t_modes;
    wr(8'hE0, 8'h01);
    check("intermittent", {15'h0000, intermittent_active}, 16'h0001);
    sense(1'b0, 1'b1, cstc_pkg::KIND_CHECK, 2, 0, 1, 3);
    wr(8'hE0, 8'h00);
    sense(1'b0, 1'b0, cstc_pkg::KIND_NORMAL, 3, 1, 2, 4);
    wr(8'hE7, 8'h00);
    sense(1'b1, 1'b0, cstc_pkg::KIND_CAL, 0, 0, 1, 3);
  endtask

  // hang guard: a stuck handshake ends the run as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      results;
    end
  end

  // reset, then the scenarios in order
  initial begin
    srst = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    sense_start = 1'b0;
    cal_request = 1'b0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    t_reset;
    t_regs;
    t_modes;
    results;
  end
endmodule
